/* File: common/cs_buffer_pkg.sv */
// Purpose: Shared constants and carriers for the channel status block buffer.
// Assumes: Byte-wide control port, one subframe strobe per transmitted subframe.
// Notes:   Figures used by the logic are named here once, except the strap frame numbers 1, 2, 3 and 15.
package cs_buffer_pkg;

  localparam logic [7:0] BUF_BASE_ADDR   = 8'h20;   // Word zero of the staging buffer.
  localparam int         BUF_WORDS       = 24;      // Words per block buffer.
  localparam int         FRAMES_PER_BLK  = 192;     // Frames in one status block.
  localparam logic [7:0] LAST_FRAME      = 8'hBF;   // Frame index 191.
  localparam logic [4:0] CHECK_BYTE_IDX  = 5'h17;   // Byte 23 carries the check byte.
  localparam logic [7:0] CRC_INIT        = 8'hFF;   // Check byte preset.
  localparam logic [7:0] CRC_POLY        = 8'h1D;   // x^8+x^4+x^3+x^2+1 without top term.
  localparam logic [1:0] SYNC_HOLD_CLKS  = 2'h3;    // Least high time of block start input.
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;   // Answer to reads outside the buffer.

  // Position of the subframe now on the line.
  typedef struct packed {
    logic [7:0] frame;
    logic       chan_b;
  } sub_pos_t;

  // Pin-strapped status entry inputs.
  typedef struct packed {
    logic copy_bit;
    logic generation;
    logic emphasis_n;
    logic audio_n;
  } hw_pins_t;

endpackage

/* File: logic/channel_status_block_buffer.sv */
// Purpose: Staging and transmit buffers for channel status with check byte insertion.
// Assumes: One ref_clk domain; pins are synchronised here before use.
// Notes:   Transmit bit is presented the cycle after each subframe strobe.
`timescale 1ns/1ps
`default_nettype none
module channel_status_block_buffer (
  input  wire logic                    ref_clk,           // 100 MHz master clock.
  input  wire logic                    rst_n,             // Synchronous reset, active low.
  input  wire logic [7:0]              ctl_addr,          // Control port byte address.
  input  wire logic [7:0]              ctl_wdata,         // Control port write byte.
  input  wire logic                    ctl_wr,            // Write strobe, one cycle.
  input  wire logic                    ctl_rd,            // Read strobe, one cycle.
  input  wire logic                    ctl_frame_start,   // New control transaction, resets byte phase.
  output logic      [7:0]              ctl_rdata,         // Read byte, valid cycle after ctl_rd.
  input  wire logic                    one_byte_mode,     // One byte per word access.
  input  wire logic                    read_chan_b,       // One byte mode reads channel B.
  input  wire logic                    copy_inhibit,      // Blocks staging to transmit copies.
  input  wire logic                    copy_irq_enable,   // Lets copies raise the interrupt.
  output logic                         copy_irq,          // Pulse on each enabled copy.
  input  wire logic                    hw_mode,           // Pin-strapped status entry.
  input  wire logic                    hw_status_entry_select, // High: serial status pin.
  input  wire cs_buffer_pkg::hw_pins_t hw_pins,           // Copy, generation, emphasis, audio pins.
  input  wire logic                    serial_status_in,  // Serial status bit pin.
  input  wire logic                    block_start_direction, // High: block start is output.
  input  wire logic                    block_start_sync_in,   // Block start pin level.
  output logic                         block_start_sync_out,  // Block start drive value.
  output logic                         block_start_sync_oe_n, // Low while driving the pin.
  input  wire logic                    subframe_strobe,   // Encoder starts a subframe.
  output logic                         cs_bit             // Status bit for current subframe.
);
  import cs_buffer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage: staging buffer visible to the host, transmit buffer for the encoder.
  logic [15:0] stage_mem [BUF_WORDS];
  logic [15:0] xmit_mem  [BUF_WORDS];

  sub_pos_t    pos_reg;
  sub_pos_t    pos_next;
  logic        copy_now;
  logic        byte_phase_reg;
  logic [7:0]  crc_a_reg;
  logic [7:0]  crc_b_reg;
  logic        pro_a_reg;
  logic        pro_b_reg;
  logic [1:0]  hold_cnt_reg;
  logic        restart_armed_reg;
  hw_pins_t    pins_s1_reg;
  hw_pins_t    pins_s2_reg;
  logic [3:0]  misc_s1_reg;
  logic [3:0]  misc_s2_reg;
  logic        serial_s;
  logic        sync_in_s;
  logic        dir_s;
  logic        entry_sel_s;
  logic        buf_hit;
  logic [4:0]  word_idx;
  logic [15:0] tx_word;
  logic        raw_bit;
  logic        out_bit;
  logic        send_crc;
  logic [4:0]  byte_idx;
  logic [2:0]  bit_idx;

  // One step of the check byte polynomial, shared by both channels.
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Two flip-flop synchronisers for every pin; only the second stage is read.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      misc_s1_reg <= 4'h0;
      misc_s2_reg <= 4'h0;
    end else begin
      pins_s1_reg <= hw_pins;
      pins_s2_reg <= pins_s1_reg;
      misc_s1_reg <= {serial_status_in, block_start_sync_in, block_start_direction, hw_status_entry_select};
      misc_s2_reg <= misc_s1_reg;
    end
  end
  assign serial_s    = misc_s2_reg[3];
  assign sync_in_s   = misc_s2_reg[2];
  assign dir_s       = misc_s2_reg[1];
  assign entry_sel_s = misc_s2_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // Control port decode of the staging buffer.
  assign buf_hit  = (ctl_addr >= BUF_BASE_ADDR) && (ctl_addr < BUF_BASE_ADDR + 8'(BUF_WORDS));
  assign word_idx = 5'(ctl_addr - BUF_BASE_ADDR);

  // Host writes; one byte mode copies the byte into both halves.
  always_ff @(posedge ref_clk) begin
    if (ctl_wr && buf_hit) begin
      if (one_byte_mode) begin
        stage_mem[word_idx] <= {ctl_wdata, ctl_wdata};
      end else if (!byte_phase_reg) begin
        stage_mem[word_idx][15:8] <= ctl_wdata;
      end else begin
        stage_mem[word_idx][7:0] <= ctl_wdata;
      end
    end
  end

  // Two byte mode alternates channel A then B for each buffer access.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || ctl_frame_start) begin
      byte_phase_reg <= 1'b0;
    end else if ((ctl_wr || ctl_rd) && buf_hit && !one_byte_mode) begin
      byte_phase_reg <= ~byte_phase_reg;
    end
  end

  // Registered read answer; outside the buffer it reads as zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl_rdata <= READ_UNMAPPED;
    end else if (ctl_rd) begin
      if (!buf_hit) begin
        ctl_rdata <= READ_UNMAPPED;
      end else if (one_byte_mode ? read_chan_b : byte_phase_reg) begin
        ctl_rdata <= stage_mem[word_idx][7:0];
      end else begin
        ctl_rdata <= stage_mem[word_idx][15:8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Block start input: three clocks high arms a restart at the next subframe.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_cnt_reg      <= 2'h0;
      restart_armed_reg <= 1'b0;
    end else begin
      hold_cnt_reg <= (sync_in_s && !dir_s) ? ((hold_cnt_reg == SYNC_HOLD_CLKS) ? hold_cnt_reg : hold_cnt_reg + 2'h1)
                                             : 2'h0;
      if (hold_cnt_reg == SYNC_HOLD_CLKS) begin
        restart_armed_reg <= 1'b1;
      end else if (subframe_strobe) begin
        restart_armed_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Position tracking; wrap or forced restart marks a block boundary.
  always_comb begin
    pos_next = pos_reg;
    if (restart_armed_reg) begin
      pos_next = '0;
    end else if (!pos_reg.chan_b) begin
      pos_next.chan_b = 1'b1;
    end else begin
      pos_next.chan_b = 1'b0;
      pos_next.frame  = (pos_reg.frame == LAST_FRAME) ? 8'h00 : pos_reg.frame + 8'h01;
    end
  end

  // Copy only at a boundary so a block never changes in flight.
  assign copy_now = subframe_strobe && (pos_next == '0) && !copy_inhibit;

  // Reset parks on the last subframe so the first strobe opens block zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_reg <= '{frame: LAST_FRAME, chan_b: 1'b1};
    end else if (subframe_strobe) begin
      pos_reg <= pos_next;
    end
  end

  // Whole-block copy; without it the old block is sent again.
  always_ff @(posedge ref_clk) begin
    if (copy_now) begin
      xmit_mem <= stage_mem;
    end
  end

  // Copy event pulse, gated by its enable.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      copy_irq <= 1'b0;
    end else begin
      copy_irq <= copy_now && copy_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit selection for the subframe that is starting.
  assign byte_idx = pos_next.frame[7:3];
  assign bit_idx  = 3'h7 - pos_next.frame[2:0];
  assign tx_word  = copy_now ? stage_mem[byte_idx] : xmit_mem[byte_idx];

  // Source of the raw bit: transmit buffer, serial pin or strapped pins.
  always_comb begin
    raw_bit = 1'b0;
    if (!hw_mode) begin
      raw_bit = pos_next.chan_b ? tx_word[{1'b0, bit_idx}] : tx_word[{1'b1, bit_idx}];
    end else if (entry_sel_s) begin
      raw_bit = serial_s;
    end else begin
      // Consumer block built from the straps; professional flag stays zero.
      case (pos_next.frame)
        8'h01:   raw_bit = pins_s2_reg.audio_n;
        8'h02:   raw_bit = pins_s2_reg.copy_bit;
        8'h03:   raw_bit = ~pins_s2_reg.emphasis_n;
        8'h0F:   raw_bit = pins_s2_reg.generation;
        default: raw_bit = 1'b0;
      endcase
    end
  end

  // Professional blocks get the computed check byte in byte 23.
  assign send_crc = (byte_idx == CHECK_BYTE_IDX) && (hw_mode ? entry_sel_s : 1'b1) &&
                    (pos_next.chan_b ? pro_b_reg : pro_a_reg);
  assign out_bit  = send_crc ? (pos_next.chan_b ? crc_b_reg[bit_idx] : crc_a_reg[bit_idx]) : raw_bit;

  // Per channel check byte and professional flag, run as bits go out.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      crc_a_reg <= CRC_INIT;
      crc_b_reg <= CRC_INIT;
      pro_a_reg <= 1'b0;
      pro_b_reg <= 1'b0;
    end else if (subframe_strobe && (byte_idx != CHECK_BYTE_IDX)) begin
      if (pos_next.chan_b) begin
        crc_b_reg <= crc_step((pos_next.frame == 8'h00) ? CRC_INIT : crc_b_reg, raw_bit);
        if (pos_next.frame == 8'h00) begin
          pro_b_reg <= raw_bit;
        end
      end else begin
        crc_a_reg <= crc_step((pos_next.frame == 8'h00) ? CRC_INIT : crc_a_reg, raw_bit);
        if (pos_next.frame == 8'h00) begin
          pro_a_reg <= raw_bit;
        end
      end
    end
  end

  // Encoder bit and block start output, both registered.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_bit               <= 1'b0;
      block_start_sync_out <= 1'b0;
    end else if (subframe_strobe) begin
      cs_bit               <= out_bit;
      block_start_sync_out <= (pos_next == '0);
    end
  end

  // Drive the pin only when configured as the block start master.
  assign block_start_sync_oe_n = ~dir_s;

endmodule // channel_status_block_buffer
`default_nettype wire

/* File: testbench/cs_host_model.sv */
// Purpose: Host model driving the control port.
// Assumes: One access at a time, two cycles each.
// Notes:   Write data flips once released.
`timescale 1ns/1ps
`default_nettype none
module cs_host_model (
  input  wire logic       ref_clk,         // Clock.
  output logic      [7:0] ctl_addr,        // Address.
  output logic      [7:0] ctl_wdata,       // Write byte.
  output logic            ctl_wr,          // Write.
  output logic            ctl_rd,          // Read.
  output logic            ctl_frame_start, // Phase restart.
  input  wire logic [7:0] ctl_rdata        // Read byte.
);
  // Quiet bus from time zero.
  initial {ctl_addr, ctl_wdata, ctl_wr, ctl_rd, ctl_frame_start} = '0;
  // Op bits are frame start, read, write; a strobe spans one edge, so each access is taken exactly once.
  task automatic xfer(input logic [2:0] op, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
    @(posedge ref_clk) #1 {ctl_addr, ctl_wdata} = {a, wd};
    {ctl_frame_start, ctl_rd, ctl_wr} = op;
    @(posedge ref_clk) #1 {ctl_frame_start, ctl_rd, ctl_wr} = 3'b000;
    ctl_wdata = ~wd;
    q = ctl_rdata;
  endtask
endmodule // cs_host_model
`default_nettype wire

/* File: testbench/cs_chk_assertions.sv */
// Purpose: Port checks for the status buffer.
// Assumes: One clock; reset low disables.
// Notes:   Bound below the module.
`timescale 1ns/1ps
`default_nettype none
module cs_chk (
  input wire logic       ref_clk,               // Clock.
  input wire logic       rst_n,                 // Reset.
  input wire logic [7:0] ctl_addr,              // Address.
  input wire logic       ctl_rd,                // Read.
  input wire logic [7:0] ctl_rdata,             // Read byte.
  input wire logic       copy_inhibit,          // Inhibit.
  input wire logic       copy_irq_enable,       // Enable.
  input wire logic       copy_irq,              // Copy pulse.
  input wire logic       block_start_direction, // Role.
  input wire logic       block_start_sync_out,  // Start.
  input wire logic       block_start_sync_oe_n, // Drive.
  input wire logic       subframe_strobe,       // Strobe.
  input wire logic       cs_bit                 // Bit.
);
  // Holds skip the edge after reset, where the past value is stale.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence idle; $past(rst_n) && !$past(subframe_strobe); endsequence
  a_rd_unmapped: assert property (ctl_rd && (ctl_addr < 8'h20 || ctl_addr > 8'h37) |=> ctl_rdata == 8'h00)
    else $error("bad read");
  a_rdata_hold: assert property ($past(rst_n) && !$past(ctl_rd) |-> $stable(ctl_rdata)) else $error("rdata");
  a_bit_hold: assert property (idle |-> $stable(cs_bit)) else $error("bit moved");
  a_start_hold: assert property (idle |-> $stable(block_start_sync_out)) else $error("start moved");
  a_irq_cause: assert property (copy_irq |-> $past(subframe_strobe && copy_irq_enable)) else $error("bad copy");
  a_irq_inhibit: assert property (copy_irq |-> !$past(copy_inhibit)) else $error("inhibited copy");
  a_irq_start: assert property (copy_irq |-> block_start_sync_out ##1 !copy_irq) else $error("bad pulse");
  a_oe_role: assert property ($stable(block_start_direction) [*4] |-> block_start_sync_oe_n != block_start_direction)
    else $error("bad drive");
  c_copy: cover property (copy_irq);
  c_start: cover property ($rose(block_start_sync_out));
  c_unmapped: cover property (ctl_rd && ctl_addr == 8'h38);
  c_restart: cover property (block_start_sync_oe_n && $rose(block_start_sync_out));
endmodule // cs_chk
bind channel_status_block_buffer cs_chk u_chk (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the status block buffer.
// Assumes: Register mode first, then a slave block restart and both strapped entry modes.
// Notes:   Seeded bytes fill the buffer; the serial pin replays the expected block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cs_buffer_pkg::*;
  logic            ref_clk = 1'b0, rst_n = 1'b0, subframe_strobe = 1'b0, one_byte_mode = 1'b0, read_chan_b = 1'b0;
  logic            copy_inhibit = 1'b0, copy_irq_enable = 1'b1, block_start_direction = 1'b1; // Lone master.
  logic            hw_mode = 1'b0, hw_status_entry_select = 1'b0;
  logic            serial_status_in = 1'b0, block_start_sync_in = 1'b0;
  hw_pins_t        hw_pins = '0;
  wire logic [7:0] ctl_addr, ctl_wdata, ctl_rdata;
  wire logic       ctl_wr, ctl_rd, ctl_frame_start, copy_irq, block_start_sync_out, block_start_sync_oe_n, cs_bit;
  logic     [15:0] st [BUF_WORDS], xm [BUF_WORDS];
  logic      [7:0] d;
  int              seed = 6309, err_count = 0, num_checks = 0;
  // Half period of 5 ns.
  always #5 ref_clk = ~ref_clk;
  // Every pin comes from the bench, which plays the board sharing clock, reset and block start.
  channel_status_block_buffer dut (.*);
  cs_host_model host (.*);
  // Byte k of channel b as sent; a professional channel carries the check byte as byte 23.
  function automatic logic [7:0] tbyte(input int k, input logic b);
    logic [7:0] c;
    c = CRC_INIT;
    if (k == 23 && xm[0][b ? 7 : 15]) begin
      for (int i = 0; i < 184; i++)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ xm[i / 8][(b ? 7 : 15) - i % 8]) ? CRC_POLY : 8'h00);
      return c;
    end
    return b ? xm[k][7:0] : xm[k][15:8];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    err_count += int'(g !== e);
    if (g !== e)
      $display("wrong value %0s expected %h seen %h", n, e, g);
  endtask
  // Random words by two-byte writes, channel A first; pro sets channel A's format bit.
  task automatic fill(input logic pro);
    host.xfer(3'b100, 8'h00, 8'h00, d);
    for (int k = 0; k < 48; k++) begin
      if (!k[0])
        st[k / 2] = {pro, 15'($random(seed))};
      host.xfer(3'b001, BUF_BASE_ADDR + 8'(k / 2), k[0] ? st[k / 2][7:0] : st[k / 2][15:8], d);
    end
  endtask
  // First n subframes of a block; the copy lands on its first strobe unless inhibited.
  // The serial pin gets each bit two edges early, so its synchroniser has settled by the strobe.
  task automatic run_block(input int n);
    if (!copy_inhibit && !hw_mode)
      xm = st;
    for (int i = 0; i < n; i++) begin
      serial_status_in = xm[i / 16][(i[0] ? 7 : 15) - (i / 2) % 8];
      repeat (2) @(posedge ref_clk);
      #1 subframe_strobe = 1'b1;
      @(posedge ref_clk) #1 subframe_strobe = 1'b0;
      d = tbyte(i / 16, i[0]);
      chk("cs_bit", {7'h00, d[7 - (i / 2) % 8]}, {7'h00, cs_bit});
      chk("copy_irq", {7'h00, i == 0 && !copy_inhibit && copy_irq_enable}, {7'h00, copy_irq});
      chk("block_start", {7'h00, i == 0}, {7'h00, block_start_sync_out});
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: access, copy, inhibited boundary, check byte.
  initial begin
    repeat (4) @(posedge ref_clk) #1;
    rst_n = 1'b1;
    fill(1'b0);
    for (int k = 0; k < 48; k++) begin
      host.xfer(3'b010, BUF_BASE_ADDR + 8'(k / 2), 8'h00, d);
      chk("stage", k[0] ? st[k / 2][7:0] : st[k / 2][15:8], d);
    end
    one_byte_mode = 1'b1;
    d = 8'($random(seed));
    st[5] = {d, d};
    host.xfer(3'b001, 8'h25, d, d);
    for (int k = 0; k < 4; k++) begin
      read_chan_b = k[0];
      host.xfer(3'b010, k < 2 ? 8'h25 : (k[0] ? 8'h38 : 8'h1F), 8'h00, d);
      chk("one_byte", k < 2 ? st[5][7:0] : 8'h00, d);
    end
    one_byte_mode = 1'b0;
    $display("test access done");
    run_block(384);
    $display("test copy done");
    copy_inhibit = 1'b1;
    fill(1'b1);
    run_block(384);
    $display("test inhibit done");
    {copy_inhibit, copy_irq_enable} = 2'b00;
    run_block(384);
    $display("test check byte done");
    // Outside logic now drives block start; a long pulse mid-block must force a new block.
    {block_start_direction, copy_irq_enable} = 2'b01;
    run_block(77);
    block_start_sync_in = 1'b1;
    repeat (6) @(posedge ref_clk) #1;
    block_start_sync_in = 1'b0;
    repeat (6) @(posedge ref_clk) #1;
    run_block(384);
    $display("test block restart done");
    // Serial entry: the pin replays a seeded block whose channel A is professional.
    {hw_mode, hw_status_entry_select} = 2'b11;
    for (int k = 0; k < 24; k++)
      xm[k] = 16'($random(seed));
    xm[0][15] = 1'b1;
    run_block(384);
    $display("test serial entry done");
    // Strap entry: seeded pins land in frames 1, 2, 3 and 15 of both channels, with no check byte.
    hw_status_entry_select = 1'b0;
    hw_pins = 4'($random(seed));
    xm = '{default: 16'h0000};
    xm[0] = {2{1'b0, hw_pins.audio_n, hw_pins.copy_bit, ~hw_pins.emphasis_n, 4'h0}};
    xm[1] = {2{7'h00, hw_pins.generation}};
    run_block(384);
    $display("test strap entry done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
